// ---- dsc_params.svh ----
// Offsets, field positions, reset values and counts of the debug session block.
// Assumes inclusion by bare name from every file that needs them.
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
// Register indices; byte address is four times the index
`define DSC_IDX_CONTROL_ONE 6'h20
`define DSC_IDX_STATUS 6'h21
`define DSC_IDX_TRACE_CTRL 6'h22
`define DSC_IDX_TRACE_COUNT 6'h26
`define DSC_IDX_SHARED 6'h27
`define DSC_IDX_WIN_FIRST 6'h28
`define DSC_IDX_WIN_LAST 6'h2F
// Control one fields
`define DSC_C1_ARM 7
`define DSC_C1_IMMEDIATE_TRIGGER_REQUEST 6
`define DSC_C1_HALT_SEL 4
`define DSC_C1_BRK_EN 3
// Trace control fields
`define DSC_TC_ENABLE 6
`define DSC_TC_MODE_LO 2
`define DSC_TC_ALIGN 0
// Status and count fields
`define DSC_SR_FULL 7
// Sequencer state flag codes
`define DSC_SSF_IDLE 3'h0
`define DSC_SSF_S1 3'h1
`define DSC_SSF_S2 3'h2
`define DSC_SSF_S3 3'h3
`define DSC_SSF_FINAL 3'h4
// Bank select codes
`define DSC_BANK_NONE 2'h3
// Reset values
`define DSC_RST_BYTE 8'h00
`define DSC_RST_BANK 2'h0
// Trace lines that make the buffer full
`define DSC_TRACE_LINES 64
`endif

// ---- dsc_pkg.sv ----
// Types shared by the debug session block.
// Assumes nothing beyond a SystemVerilog compiler.
package dsc_pkg;
	typedef enum logic [4:0] {
		DSC_ST_IDLE = 5'h01,
		DSC_ST_S1 = 5'h02,
		DSC_ST_S2 = 5'h04,
		DSC_ST_S3 = 5'h08,
		DSC_ST_FINAL = 5'h10
	} dsc_state_t;
endpackage

// ---- dsc_sequencer.sv ----
// State sequencer of the debug session and its state flags.
// Assumes advance requests come from comparator logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"
module dsc_sequencer
	import dsc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Session control
	input wire logic armed,
	input wire logic arm_set,
	input wire logic end_int,
	input wire logic immediate_trigger_request,
	// Comparator advance request
	input wire logic adv_valid,
	input wire logic [2:0] adv_code,
	// State out
	output logic [2:0] flags_reg,
	output logic final_pulse_reg
);
	dsc_state_t state_reg, state_next;
	logic [2:0] flags_next;
	logic final_next;

	always_comb begin
		state_next = state_reg;
		flags_next = flags_reg;
		final_next = 1'b0;
		if (end_int) begin
			state_next = DSC_ST_IDLE;
			flags_next = `DSC_SSF_IDLE;
		end else if (arm_set) begin
			state_next = DSC_ST_S1;
			flags_next = `DSC_SSF_S1;
		end else if (armed && state_reg != DSC_ST_FINAL) begin
			if (immediate_trigger_request) begin
				state_next = DSC_ST_FINAL;
				flags_next = `DSC_SSF_FINAL;
				final_next = 1'b1;
			end else if (adv_valid) begin
				// Reserved and idle codes are never taken
				unique case (adv_code)
					`DSC_SSF_S1: begin
						state_next = DSC_ST_S1;
						flags_next = adv_code;
					end
					`DSC_SSF_S2: begin
						state_next = DSC_ST_S2;
						flags_next = adv_code;
					end
					`DSC_SSF_S3: begin
						state_next = DSC_ST_S3;
						flags_next = adv_code;
					end
					`DSC_SSF_FINAL: begin
						state_next = DSC_ST_FINAL;
						flags_next = adv_code;
						final_next = 1'b1;
					end
					default: begin
						state_next = state_reg;
					end
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= DSC_ST_IDLE;
			flags_reg <= `DSC_SSF_IDLE;
			final_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			flags_reg <= flags_next;
			final_pulse_reg <= final_next;
		end
	end

	chk_flags_legal: assert property (@(posedge sys_clk) disable iff (sys_rst)
		flags_reg <= `DSC_SSF_FINAL) else $error("state flags hold a reserved code");
endmodule
`default_nettype wire

// ---- dsc_break_router.sv ----
// Routes a breakpoint to halt mode or software interrupt.
// Assumes halt mode status comes from the background controller on this clock.
`timescale 1ns/1ps
`default_nettype none
module dsc_break_router (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Breakpoint request and steering
	input wire logic brk_fire,
	input wire logic halt_sel,
	input wire logic halt_mode_enable,
	input wire logic halt_active,
	// Outputs, one-cycle pulses
	output logic halt_req_reg,
	output logic swi_req_reg
);
	wire logic to_halt = brk_fire && halt_sel && halt_mode_enable;
	wire logic to_swi = brk_fire && (halt_sel ? !halt_mode_enable : !halt_active);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			halt_req_reg <= 1'b0;
			swi_req_reg <= 1'b0;
		end else begin
			halt_req_reg <= to_halt;
			swi_req_reg <= to_swi;
		end
	end
endmodule
`default_nettype wire

// ---- dsc_top.sv ----
// Debug session control and status with its APB register slave.
// Assumes all core-side inputs run on sys_clk; por_rst marks power-on only.
// Behaviour
// - Arm and bank select writable any time
// - Trigger writable always, reads zero
// - Breakpoint bits writable only while disarmed
// - Disarming write keeps breakpoint bits
// - Hardware disarms at session end
// - Arming enters state one, flags 001
// - Trigger one forces final; zero ignored
// - Tracing disabled means trigger starts nothing
// - Secure mode blocks all tracing
// - Trigger ignored once begin-aligned tracing runs
// - Trigger with arm ends session
// - Halt select steers breakpoint destination
// - Final state breaks, after tracing if enabled
// - Bank select maps comparator window
// - Bank select picks shared address register
// - Full flag after 64 stored lines
// - Arming and power-on clear full flag
// - Full flag visible in status, count
// - Flags follow transitions, kept on disarm
// - Internal end returns idle, flags zero
// - Three-bit flag encoding of states
// - Armed blocks writes to other bits
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"
module dsc_top
	import dsc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and resets
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic por_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Chip and halt mode status
	input wire logic secure,
	input wire logic halt_mode_enable,
	input wire logic halt_active,
	// Comparator side
	input wire logic adv_valid,
	input wire logic [2:0] adv_code,
	input wire logic [2:0] match_flags,
	input wire logic [7:0] comp_rdata,
	output logic [1:0] comp_bank,
	output logic comp_wr,
	output logic [2:0] comp_offset,
	output logic [7:0] comp_wdata,
	// Trace side
	input wire logic trace_line_stored,
	input wire logic trace_complete,
	output logic trace_run,
	output logic [1:0] trace_mode,
	// Breakpoint outputs
	output logic halt_req,
	output logic swi_req
);
	initial begin
		if (ADDR_W < 8) begin
			$error("ADDR_W must reach the register map");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register state
	logic arm_reg, arm_next;
	logic halt_sel_reg, halt_sel_next;
	logic brk_en_reg, brk_en_next;
	logic [1:0] bank_reg, bank_next;
	logic trace_en_reg, trace_en_next;
	logic align_reg, align_next;
	logic [1:0] mode_reg, mode_next;
	logic [3:0] scr_reg [3];
	logic full_reg, full_next;
	logic [5:0] cnt_reg, cnt_next;
	logic trace_run_reg, trace_run_next;
	logic pready_reg;
	logic pslverr_reg;
	logic [31:0] prdata_reg;
	logic comp_wr_reg;
	logic [2:0] comp_offset_reg;
	logic [7:0] comp_wdata_reg;
	logic [2:0] flags;
	logic final_pulse;

	////////////////////////////////////////////////////////////////////////
	// APB decode; one wait state, pready comes from a flop
	wire logic access = psel && penable;
	wire logic [5:0] idx = paddr[7:2];
	wire logic aligned = paddr[1:0] == 2'h0;
	wire logic hi_zero = (ADDR_W == 8) ? 1'b1 : (paddr >> 8) == '0;
	wire logic in_win = idx >= `DSC_IDX_WIN_FIRST && idx <= `DSC_IDX_WIN_LAST;
	wire logic mapped = aligned && hi_zero && (in_win || idx == `DSC_IDX_CONTROL_ONE ||
		idx == `DSC_IDX_STATUS || idx == `DSC_IDX_TRACE_CTRL ||
		idx == `DSC_IDX_TRACE_COUNT || idx == `DSC_IDX_SHARED);
	wire logic wr = access && pready_reg && pwrite && mapped;
	wire logic [7:0] wd = pwdata[7:0];
	wire logic w_c1 = wr && idx == `DSC_IDX_CONTROL_ONE;
	// Armed blocks everything but arm, trigger and bank select
	wire logic w_open = wr && !arm_reg;
	wire logic w_tc = w_open && idx == `DSC_IDX_TRACE_CTRL;
	wire logic w_scr = w_open && idx == `DSC_IDX_SHARED && bank_reg != `DSC_BANK_NONE;
	wire logic w_win = w_open && in_win && bank_reg != `DSC_BANK_NONE;

	////////////////////////////////////////////////////////////////////////
	// Session events
	wire logic immediate_trigger_request_wr = w_c1 && wd[`DSC_C1_IMMEDIATE_TRIGGER_REQUEST];
	wire logic arm_one = w_c1 && wd[`DSC_C1_ARM];
	wire logic begin_running = trace_run_reg && align_reg;
	// Begin-aligned tracing already runs: trigger with arm must not cut it short
	wire logic immediate_trigger_request_end = immediate_trigger_request_wr && arm_one && !begin_running;
	wire logic arm_set = arm_one && !immediate_trigger_request_wr;
	wire logic tracing_ok = trace_en_reg && !secure;
	wire logic immediate_trigger_request_eff = immediate_trigger_request_wr && !arm_one && arm_reg && !begin_running;
	wire logic trace_start = tracing_ok &&
		((arm_set && !align_reg) || (final_pulse && align_reg));
	wire logic trace_stop = trace_run_reg &&
		((align_reg && trace_complete) || (!align_reg && final_pulse));
	wire logic untraced_final = final_pulse && !tracing_ok;
	wire logic session_done = arm_reg && (trace_stop || untraced_final);
	wire logic brk_fire = brk_en_reg && session_done;
	wire logic end_int = session_done || immediate_trigger_request_end;

	////////////////////////////////////////////////////////////////////////
	// Next values of control state
	assign arm_next = end_int ? 1'b0 : (w_c1 ? wd[`DSC_C1_ARM] : arm_reg);
	// Old arm value gates these, so a disarming write leaves them alone
	assign halt_sel_next = (w_c1 && !arm_reg) ? wd[`DSC_C1_HALT_SEL] : halt_sel_reg;
	assign brk_en_next = (w_c1 && !arm_reg) ? wd[`DSC_C1_BRK_EN] : brk_en_reg;
	assign bank_next = w_c1 ? wd[1:0] : bank_reg;
	// Enable cannot be set while secure
	assign trace_en_next = w_tc ? (wd[`DSC_TC_ENABLE] && !secure) : trace_en_reg;
	assign align_next = w_tc ? wd[`DSC_TC_ALIGN] : align_reg;
	assign mode_next = w_tc ? wd[`DSC_TC_MODE_LO+1:`DSC_TC_MODE_LO] : mode_reg;
	assign trace_run_next = !secure && arm_next && (trace_start || (trace_run_reg && !trace_stop));
	// A line in the arming cycle still counts
	wire logic line_in = trace_line_stored && trace_run_reg;
	wire logic full_set = line_in && cnt_reg == 6'(`DSC_TRACE_LINES - 1);
	assign cnt_next = arm_one ? 6'(line_in) : (line_in ? cnt_reg + 6'h01 : cnt_reg);
	assign full_next = full_set ? 1'b1 : (arm_one ? 1'b0 : full_reg);

	always_ff @(posedge sys_clk or posedge sys_rst or posedge por_rst) begin
		if (sys_rst || por_rst) begin
			arm_reg <= 1'b0;
			halt_sel_reg <= 1'b0;
			brk_en_reg <= 1'b0;
			bank_reg <= `DSC_RST_BANK;
			trace_en_reg <= 1'b0;
			align_reg <= 1'b0;
			mode_reg <= 2'h0;
			cnt_reg <= 6'h00;
			trace_run_reg <= 1'b0;
		end else begin
			arm_reg <= arm_next;
			halt_sel_reg <= halt_sel_next;
			brk_en_reg <= brk_en_next;
			bank_reg <= bank_next;
			trace_en_reg <= trace_en_next;
			align_reg <= align_next;
			mode_reg <= mode_next;
			cnt_reg <= cnt_next;
			trace_run_reg <= trace_run_next;
		end
	end

	// Of the resets only power-on clears the full flag; sys_rst keeps it
	always_ff @(posedge sys_clk or posedge por_rst) begin
		if (por_rst) begin
			full_reg <= 1'b0;
		end else begin
			full_reg <= full_next;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_scr
			always_ff @(posedge sys_clk or posedge sys_rst or posedge por_rst) begin
				if (sys_rst || por_rst) begin
					scr_reg[gi] <= 4'h0;
				end else if (w_scr && bank_reg == 2'(gi)) begin
					scr_reg[gi] <= wd[3:0];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Read data
	wire logic [7:0] rd_c1 = {arm_reg, 1'b0, 1'b0, halt_sel_reg, brk_en_reg, 1'b0, bank_reg};
	wire logic [7:0] rd_sr = {full_reg, 4'h0, flags};
	wire logic [7:0] rd_tc = {1'b0, trace_en_reg, 2'h0, mode_reg, 1'b0, align_reg};
	wire logic [7:0] rd_cnt = {full_reg, 1'b0, cnt_reg};
	wire logic [7:0] rd_shared = (bank_reg == `DSC_BANK_NONE) ? {5'h00, match_flags} :
		{4'h0, scr_reg[bank_reg]};
	wire logic [7:0] rd_win = (bank_reg == `DSC_BANK_NONE) ? 8'h00 : comp_rdata;
	wire logic [7:0] rd_byte = in_win ? rd_win :
		(idx == `DSC_IDX_CONTROL_ONE) ? rd_c1 :
		(idx == `DSC_IDX_STATUS) ? rd_sr :
		(idx == `DSC_IDX_TRACE_CTRL) ? rd_tc :
		(idx == `DSC_IDX_TRACE_COUNT) ? rd_cnt :
		(idx == `DSC_IDX_SHARED) ? rd_shared : `DSC_RST_BYTE;
	wire logic take = access && !pready_reg;

	// Status register writes fall through: no next value uses them
	always_ff @(posedge sys_clk or posedge sys_rst or posedge por_rst) begin
		if (sys_rst || por_rst) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			comp_wr_reg <= 1'b0;
			comp_offset_reg <= 3'h0;
			comp_wdata_reg <= `DSC_RST_BYTE;
		end else begin
			pready_reg <= take;
			pslverr_reg <= take && !mapped;
			prdata_reg <= (take && !pwrite && mapped) ? {24'h000000, rd_byte} : 32'h0000_0000;
			comp_wr_reg <= w_win;
			comp_offset_reg <= w_win ? paddr[4:2] : comp_offset_reg;
			comp_wdata_reg <= w_win ? wd : comp_wdata_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Submodules
	dsc_sequencer u_seq (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst || por_rst),
		.armed(arm_reg),
		.arm_set(arm_set),
		.end_int(end_int),
		.immediate_trigger_request(immediate_trigger_request_eff),
		.adv_valid(adv_valid),
		.adv_code(adv_code),
		.flags_reg(flags),
		.final_pulse_reg(final_pulse)
	);

	dsc_break_router u_brk (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst || por_rst),
		.brk_fire(brk_fire),
		.halt_sel(halt_sel_reg),
		.halt_mode_enable(halt_mode_enable),
		.halt_active(halt_active),
		.halt_req_reg(halt_req),
		.swi_req_reg(swi_req)
	);

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign comp_bank = bank_reg;
	assign comp_wr = comp_wr_reg;
	assign comp_offset = comp_offset_reg;
	assign comp_wdata = comp_wdata_reg;
	assign trace_run = trace_run_reg;
	assign trace_mode = mode_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	chk_bank_any_time: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		w_c1 |=> bank_reg == $past(wd[1:0])) else $error("bank select write lost");
	chk_immediate_trigger_request_reads_zero: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		pready_reg && !pslverr_reg && $past(idx) == `DSC_IDX_CONTROL_ONE |-> !prdata_reg[6])
		else $error("trigger bit read back as one");
	chk_brk_bits_locked: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		arm_reg |=> $stable(halt_sel_reg) && $stable(brk_en_reg)) else $error("breakpoint bits changed while armed");
	chk_arm_state_one: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		arm_set && !end_int |=> flags == `DSC_SSF_S1 && arm_reg) else $error("arming did not reach state one");
	chk_internal_end: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		session_done |=> !arm_reg && flags == `DSC_SSF_IDLE) else $error("internal end left session alive");
	chk_immediate_trigger_request_final: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		immediate_trigger_request_eff |=> final_pulse ##1 (!tracing_ok || !$past(brk_en_reg, 2) || trace_run_reg || !arm_reg))
		else $error("trigger did not reach final state");
	chk_secure_no_trace: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		secure |=> !trace_run_reg) else $error("tracing while secure");
	chk_untraced_break: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		untraced_final && arm_reg && brk_en_reg |=> halt_req || swi_req || (!halt_sel_reg && halt_active))
		else $error("untraced breakpoint not issued");
	chk_full_sets: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		full_set |=> full_reg && rd_cnt[7]) else $error("full flag not set at last line");
	chk_disarm_keeps: assert property (@(posedge sys_clk) disable iff (sys_rst || por_rst)
		w_c1 && arm_reg && !wd[`DSC_C1_ARM] && !end_int && !immediate_trigger_request_eff && !adv_valid |=> $stable(flags))
		else $error("flags lost on disarm");
endmodule
`default_nettype wire

// ---- dsc_core_model.sv ----
// Behavioural trace buffer, comparator and background controller beside the debug block.
// Assumes the testbench calls its tasks; everything runs on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module dsc_core_model (
	// Clock
	input wire logic sys_clk,
	// Comparator side
	input wire logic [1:0] comp_bank,
	output logic adv_valid,
	output logic [2:0] adv_code,
	output logic [2:0] match_flags,
	output logic [7:0] comp_rdata,
	// Trace and breakpoint side
	input wire logic trace_run,
	input wire logic halt_req,
	input wire logic swi_req,
	output logic trace_line_stored,
	output logic trace_complete,
	output logic halt_mode_enable,
	output logic halt_active
);
	int halt_cnt = 0;
	int swi_cnt = 0;
	int run_cyc = 0;
	logic [7:0] spin = 8'h00;
	initial begin
		adv_valid = 1'b0;
		adv_code = 3'h0;
		match_flags = 3'h5;
		trace_line_stored = 1'b0;
		trace_complete = 1'b0;
		halt_mode_enable = 1'b0;
		halt_active = 1'b0;
	end
	// No bank mapped: data changes every cycle so a stale value cannot pass
	assign comp_rdata = (comp_bank == 2'h3) ? spin : {6'h28, comp_bank};
	always @(posedge sys_clk) begin
		spin <= spin + 8'h01;
		halt_cnt <= halt_cnt + (halt_req ? 1 : 0);
		swi_cnt <= swi_cnt + (swi_req ? 1 : 0);
		run_cyc <= run_cyc + (trace_run ? 1 : 0);
	end
	////////////////////////////////////////////////////////////////
	task automatic pulse_adv(input logic [2:0] code);
		@(posedge sys_clk);
		adv_valid <= 1'b1;
		adv_code <= code;
		@(posedge sys_clk);
		adv_valid <= 1'b0;
	endtask
	// Back-to-back stored lines, one per cycle
	task automatic store(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			trace_line_stored <= 1'b1;
		end
		@(posedge sys_clk);
		trace_line_stored <= 1'b0;
	endtask
	task automatic complete();
		@(posedge sys_clk);
		trace_complete <= 1'b1;
		@(posedge sys_clk);
		trace_complete <= 1'b0;
	endtask
	task automatic set_match(input logic [2:0] m);
		@(posedge sys_clk);
		match_flags <= m;
	endtask
	task automatic set_halt(input logic en, input logic act);
		@(posedge sys_clk);
		halt_mode_enable <= en;
		halt_active <= act;
	endtask
endmodule
`default_nettype wire

// ---- dsc_top_tb.sv ----
// Self-checking testbench of the debug session block over APB.
// Assumes dsc_core_model stands on the core side; one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"
module dsc_top_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic por_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic secure = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, hme, hact, adv_valid, line_st, tr_done, comp_wr, trace_run, halt_req, swi_req;
	wire logic [2:0] adv_code, match_flags, comp_offset;
	wire logic [7:0] comp_rdata, comp_wdata;
	wire logic [1:0] comp_bank, trace_mode;
	int err_count = 0;
	int samples_checked = 0;
	localparam logic [7:0] A_C1 = {`DSC_IDX_CONTROL_ONE, 2'b00};
	localparam logic [7:0] A_SR = {`DSC_IDX_STATUS, 2'b00};
	localparam logic [7:0] A_TC = {`DSC_IDX_TRACE_CTRL, 2'b00};
	localparam logic [7:0] A_CNT = {`DSC_IDX_TRACE_COUNT, 2'b00};
	localparam logic [7:0] A_SH = {`DSC_IDX_SHARED, 2'b00};
	localparam logic [7:0] A_WIN = {`DSC_IDX_WIN_FIRST, 2'b00};
	always #50 sys_clk = ~sys_clk;
	dsc_top #(.ADDR_W(8)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .por_rst(por_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .secure(secure), .halt_mode_enable(hme), .halt_active(hact), .adv_valid(adv_valid),
		.adv_code(adv_code), .match_flags(match_flags), .comp_rdata(comp_rdata), .comp_bank(comp_bank),
		.comp_wr(comp_wr), .comp_offset(comp_offset), .comp_wdata(comp_wdata), .trace_line_stored(line_st),
		.trace_complete(tr_done), .trace_run(trace_run), .trace_mode(trace_mode), .halt_req(halt_req),
		.swi_req(swi_req));
	dsc_core_model core (.sys_clk(sys_clk), .comp_bank(comp_bank), .adv_valid(adv_valid), .adv_code(adv_code),
		.match_flags(match_flags), .comp_rdata(comp_rdata), .trace_run(trace_run), .halt_req(halt_req),
		.swi_req(swi_req), .trace_line_stored(line_st), .trace_complete(tr_done), .halt_mode_enable(hme),
		.halt_active(hact));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Pready is judged at the rising edge; data and error are taken at that same edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] rd,
		output logic err);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n > 20) begin
				err_count++;
				finish_test();
			end
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		logic e;
		apb(1'b1, a, d, v, e);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		logic e;
		apb(1'b0, a, 8'h00, v, e);
		chk(v, exp);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] v;
		logic e;
		rd_chk(A_C1, 8'h00);
		rd_chk(A_SR, 8'h00);
		wr(A_SR, 8'hFF);
		rd_chk(A_SR, 8'h00);
		// Unmapped word answers with an error
		apb(1'b0, 8'h04, 8'h00, v, e);
		chk({7'h00, e}, 8'h01);
	endtask
	task automatic t_config();
		wr(A_C1, 8'h1A);
		rd_chk(A_C1, 8'h1A);
		wr(A_C1, 8'h9A);
		rd_chk(A_C1, 8'h9A);
		rd_chk(A_SR, 8'h01);
		wr(A_C1, 8'h81);
		rd_chk(A_C1, 8'h99);
		wr(A_TC, 8'h41);
		rd_chk(A_TC, 8'h00);
		wr(A_C1, 8'h02);
		rd_chk(A_C1, 8'h1A);
		rd_chk(A_SR, 8'h01);
		wr(A_C1, 8'h00);
		rd_chk(A_C1, 8'h00);
		wr(A_C1, 8'h40);
		rd_chk(A_C1, 8'h00);
	endtask
	task automatic t_sequence();
		int s;
		wr(A_C1, 8'h88);
		core.pulse_adv(3'h2);
		core.pulse_adv(3'h3);
		rd_chk(A_SR, 8'h03);
		core.pulse_adv(3'h6);
		rd_chk(A_SR, 8'h03);
		s = core.swi_cnt;
		core.pulse_adv(3'h4);
		repeat (4) @(posedge sys_clk);
		chk(8'(core.swi_cnt - s), 8'h01);
		rd_chk(A_C1, 8'h08);
		rd_chk(A_SR, 8'h00);
		wr(A_C1, 8'h00);
	endtask
	task automatic t_route();
		logic [2:0] cs [4] = '{3'b110, 3'b100, 3'b000, 3'b011};
		logic [7:0] eh [4] = '{8'h01, 8'h00, 8'h00, 8'h00};
		logic [7:0] es [4] = '{8'h00, 8'h01, 8'h01, 8'h00};
		int h;
		int s;
		for (int i = 0; i < 4; i++) begin
			wr(A_C1, 8'h00);
			core.set_halt(cs[i][1], cs[i][0]);
			wr(A_C1, {3'b100, cs[i][2], 4'h8});
			h = core.halt_cnt;
			s = core.swi_cnt;
			core.pulse_adv(3'h4);
			repeat (4) @(posedge sys_clk);
			chk(8'(core.halt_cnt - h), eh[i]);
			chk(8'(core.swi_cnt - s), es[i]);
		end
		core.set_halt(1'b0, 1'b0);
		wr(A_C1, 8'h00);
	endtask
	task automatic t_immediate_trigger_request();
		wr(A_C1, 8'h80);
		core.pulse_adv(3'h2);
		wr(A_C1, 8'hC0);
		rd_chk(A_C1, 8'h00);
		rd_chk(A_SR, 8'h00);
	endtask
	task automatic t_trace();
		logic [7:0] v;
		logic e;
		int r;
		int s;
		wr(A_TC, 8'h40);
		wr(A_C1, 8'h80);
		@(posedge sys_clk);
		chk({7'h00, trace_run}, 8'h01);
		core.store(63);
		rd_chk(A_SR, 8'h01);
		core.store(1);
		rd_chk(A_SR, 8'h81);
		apb(1'b0, A_CNT, 8'h00, v, e);
		chk(v & 8'h80, 8'h80);
		wr(A_C1, 8'h80);
		rd_chk(A_SR, 8'h01);
		core.store(64);
		wr(A_C1, 8'h00);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd_chk(A_SR, 8'h80);
		por_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		por_rst <= 1'b0;
		rd_chk(A_SR, 8'h00);
		wr(A_TC, 8'h40);
		secure <= 1'b1;
		wr(A_C1, 8'h80);
		@(posedge sys_clk);
		chk({7'h00, trace_run}, 8'h00);
		wr(A_C1, 8'hC0);
		secure <= 1'b0;
		wr(A_TC, 8'h00);
		r = core.run_cyc;
		wr(A_C1, 8'h80);
		core.pulse_adv(3'h4);
		chk(8'(core.run_cyc - r), 8'h00);
		wr(A_C1, 8'h00);
		wr(A_TC, 8'h41);
		wr(A_C1, 8'h88);
		s = core.swi_cnt;
		core.pulse_adv(3'h4);
		repeat (2) @(posedge sys_clk);
		wr(A_C1, 8'hC0);
		@(posedge sys_clk);
		chk({7'h00, trace_run}, 8'h01);
		chk(8'(core.swi_cnt - s), 8'h00);
		core.complete();
		repeat (2) @(posedge sys_clk);
		chk({7'h00, trace_run}, 8'h00);
		chk(8'(core.swi_cnt - s), 8'h01);
		wr(A_C1, 8'h00);
		wr(A_TC, 8'h00);
	endtask
	task automatic t_bank();
		for (int b = 0; b < 3; b++) begin
			wr(A_C1, 8'(b));
			wr(A_SH, 8'(9 + b));
		end
		for (int b = 0; b < 4; b++) begin
			wr(A_C1, 8'(b));
			@(posedge sys_clk);
			chk({6'h00, comp_bank}, 8'(b));
			rd_chk(A_SH, (b == 3) ? 8'h05 : 8'(9 + b));
			rd_chk(A_WIN + 8'h04, (b == 3) ? 8'h00 : {6'h28, 2'(b)});
		end
		core.set_match(3'h2);
		rd_chk(A_SH, 8'h02);
		wr(A_C1, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		por_rst <= 1'b0;
		t_reset();
		t_config();
		t_sequence();
		t_route();
		t_immediate_trigger_request();
		t_trace();
		t_bank();
		finish_test();
	end
endmodule
`default_nettype wire
